// ---- inc/event_counter_pkg.sv ----
/*
  constants for the dual event counter unit: register selectors, setup
  field positions, widths, reset values and pin timing.
  assumes a core that reaches the registers through its own model-register
  access path and hands in per-cycle event counts for each counter.
*/
package event_counter_pkg;

  // ==========================================================
  // register selectors on the model-register access port
  localparam logic [1:0] SEL_SETUP_0 = 2'h0; // event_setup_0
  localparam logic [1:0] SEL_SETUP_1 = 2'h1; // event_setup_1
  localparam logic [1:0] SEL_TALLY_0 = 2'h2; // event_tally_0
  localparam logic [1:0] SEL_TALLY_1 = 2'h3; // event_tally_1

  // ==========================================================
  // setup register field positions
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 7;
  localparam int QUAL_LSB = 8;
  localparam int QUAL_MSB = 15;
  localparam int USER_BIT = 16;
  localparam int SUPER_BIT = 17;
  localparam int EDGE_BIT = 18;
  localparam int PIN_BIT = 19;
  localparam int IRQ_BIT = 20;
  localparam int GLOBAL_BIT = 22;
  localparam int FLIP_BIT = 23;
  localparam int THRESH_LSB = 24;
  localparam int THRESH_MSB = 31;

  // ==========================================================
  // widths and reset values
  localparam int TALLY_W = 40;
  localparam int LOW_W = 32;
  localparam int SIGN_BIT = 31;
  localparam int EVT_W = 8;
  localparam int PERMIT_BIT = 8; // user_read_permit in control_register_four
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;
  localparam logic [39:0] TALLY_RESET = 40'h00_0000_0000;

  // ==========================================================
  // bus clock divider: core 40 MHz, bus clock enable every BUS_DIV cycles
  localparam int BUS_DIV = 2;
  localparam logic [3:0] BUS_DIV_LAST = 4'(BUS_DIV - 1);

endpackage

// ---- rtl/tally_lane.sv ----
/*
  one counter lane: qualifies the per-cycle event count by privilege,
  threshold, invert and edge, keeps the 40-bit tally and its carry out.
  assumes event counts arrive from logic on clk_sys; no synchroniser.
*/
`timescale 1ns/1ps
module tally_lane
  import event_counter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [31:0] setup,
  input wire logic laneOn,
  input wire logic [1:0] privLevel,
  input wire logic [7:0] eventCount,
  input wire logic loadStrobe,
  input wire logic [31:0] loadData,
  output logic [39:0] tally,
  output logic counted,
  output logic wrapped
);

  // ==========================================================
  // lane state
  typedef struct packed {
    logic [39:0] tally;   // running count
    logic lastCond;       // qualified condition of the previous cycle
    logic counted;        // a count was taken this cycle
    logic wrapped;        // carry out of bit 39 this cycle
  } lane_type;

  lane_type cur;
  lane_type next_cur;

  logic privOk;
  logic cond;
  logic [39:0] step;
  logic [40:0] sum;
  logic [7:0] thresh;

  // ==========================================================
  // qualify and add
  always_comb begin
    next_cur = cur;
    thresh = setup[THRESH_MSB:THRESH_LSB];
    // level 0 counts under the supervisor flag, 1..3 under user
    privOk = (privLevel == 2'h0) ? setup[SUPER_BIT]
                                  : setup[USER_BIT];
    // threshold compare, flipped when asked
    if (thresh != 8'h00) begin
      cond = (eventCount >= thresh) ^ setup[FLIP_BIT];
    end else begin
      cond = (eventCount != 8'h00); // duration events arrive as 1
    end
    cond = cond & privOk & laneOn;
    // amount to add
    if (setup[EDGE_BIT]) begin
      step = {39'h0, cond & ~cur.lastCond};
    end else if (thresh != 8'h00) begin
      step = {39'h0, cond};
    end else begin
      step = (privOk && laneOn) ? {32'h0, eventCount}
                                : 40'h00_0000_0000;
    end
    sum = {1'b0, cur.tally} + {1'b0, step};
    next_cur.lastCond = cond;
    next_cur.counted = (step != 40'h00_0000_0000);
    next_cur.wrapped = sum[TALLY_W];
    next_cur.tally = sum[39:0];
    // a load wins over counting; upper byte copies bit 31
    if (loadStrobe) begin
      next_cur.tally = {{8{loadData[SIGN_BIT]}}, loadData};
      next_cur.wrapped = 1'b0;
      next_cur.counted = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tally = cur.tally;
  assign counted = cur.counted;
  assign wrapped = cur.wrapped;

endmodule

// ---- rtl/dual_event_counter_unit.sv ----
/*
  dual event counter unit: two setup registers, two 40-bit tallies,
  privileged model-register access, counter-read instruction path,
  monitor pins and overflow interrupt requests.
  assumes the core presents privilege level, mode and control register
  four bits on clk_sys, and event counts per cycle from its own logic.
*/
// Contract
// - low byte selects the monitored event
// - bits 8-15 qualify the chosen event
// - user flag counts at levels one-three
// - supervisor flag counts at level zero
// - edge flag counts rising transitions only
// - pin toggle is one bus clock high
// - interrupt flag raises overflow interrupt request
// - global enable in first setup, both
// - invert flag flips threshold compare
// - nonzero threshold adds one when met
// - zero threshold adds cycle event count
// - counter read gated by user permit
// - counter read samples without serialising
// - model-register access only at level zero
// - tally writes sign-extend bit 31
// - counting starts right after enable write
// - stop on enable clear or cleared setups
// - clearing second setup stops second only
// - two counters, forty bits each
// - duration mode counts true cycles
`timescale 1ns/1ps
module dual_event_counter_unit
  import event_counter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] privLevel,
  input wire logic v86Mode,
  input wire logic [31:0] controlRegisterFour,
  input wire logic [7:0] eventCount0,
  input wire logic [7:0] eventCount1,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [1:0] regSel,
  input wire logic [31:0] regWriteData,
  output logic [39:0] regReadData,
  output logic regFault,
  input wire logic counterRead,
  input wire logic counterIndex,
  output logic [39:0] counterReadData,
  output logic counterReadFault,
  output logic [7:0] setupCode0,
  output logic [7:0] setupCode1,
  output logic [7:0] unitQualifier0,
  output logic [7:0] unitQualifier1,
  output logic [1:0] monitorEventPin,
  output logic [1:0] overflowIrq
);

  // ==========================================================
  // unit state, one struct registered as a whole
  typedef struct packed {
    logic [31:0] setup0;        // event_setup_0
    logic [31:0] setup1;        // event_setup_1
    logic [39:0] readData;      // register read answer
    logic regFault;             // refused model-register access
    logic [39:0] ctrData;       // counter-read answer
    logic ctrFault;             // refused counter read
    logic [1:0] pinPending;     // toggle waiting for a bus clock
    logic [1:0] pin;            // monitor pin level
    logic [1:0] irq;            // overflow interrupt pulse
    logic [3:0] busDiv;         // bus clock enable divider
  } unit_type;

  unit_type cur;
  unit_type next_cur;

  logic laneOn0;
  logic laneOn1;
  logic load0;
  logic load1;
  logic [39:0] tally0;
  logic [39:0] tally1;
  logic counted0;
  logic counted1;
  logic wrapped0;
  logic wrapped1;
  logic busTick;
  logic privileged;
  logic [1:0] toggleReq;
  logic [39:0] laneTally [2]; // per-lane tally, indexed by lane
  logic [1:0] laneCounted;    // per-lane count taken
  logic [1:0] laneWrapped;    // per-lane carry out

  // ==========================================================
  // lane enables: global bit only in the first setup register
  // an all-zero setup has no privilege flag set, so its lane stops too
  assign laneOn0 = cur.setup0[GLOBAL_BIT];
  assign laneOn1 = cur.setup0[GLOBAL_BIT]
                   & (cur.setup1 != SETUP_RESET);
  assign privileged = (privLevel == 2'h0);
  assign load0 = regWrite & privileged & (regSel == SEL_TALLY_0);
  assign load1 = regWrite & privileged & (regSel == SEL_TALLY_1);
  assign busTick = (cur.busDiv == BUS_DIV_LAST);

  // ==========================================================
  // the two counters, one lane each
  generate
    for (genvar i = 0; i < 2; i++) begin : g_lane
      tally_lane u_lane (
        .clk_sys(clk_sys),
        .rst(rst),
        .setup(i == 0 ? cur.setup0 : cur.setup1),
        .laneOn(i == 0 ? laneOn0 : laneOn1),
        .privLevel(privLevel),
        .eventCount(i == 0 ? eventCount0 : eventCount1),
        .loadStrobe(i == 0 ? load0 : load1),
        .loadData(regWriteData),
        .tally(laneTally[i]),
        .counted(laneCounted[i]),
        .wrapped(laneWrapped[i])
      );
    end
  endgenerate

  // lane outputs through plain nets, one driver each
  assign tally0 = laneTally[0];
  assign tally1 = laneTally[1];
  assign counted0 = laneCounted[0];
  assign counted1 = laneCounted[1];
  assign wrapped0 = laneWrapped[0];
  assign wrapped1 = laneWrapped[1];

  // pin request follows the pin-select flag per lane
  assign toggleReq[0] = cur.setup0[PIN_BIT] ? counted0 : wrapped0;
  assign toggleReq[1] = cur.setup1[PIN_BIT] ? counted1 : wrapped1;

  // ==========================================================
  // register access, pins and interrupts
  always_comb begin
    next_cur = cur;
    next_cur.irq = 2'b00;
    next_cur.busDiv = busTick ? 4'h0 : cur.busDiv + 4'h1;

    // model-register access, level zero only
    next_cur.regFault = (regRead | regWrite) & ~privileged;
    if (regWrite && privileged) begin
      // new setup takes effect the next cycle
      unique case (regSel)
        SEL_SETUP_0: next_cur.setup0 = regWriteData;
        SEL_SETUP_1: next_cur.setup1 = regWriteData;
        SEL_TALLY_0: next_cur.setup0 = cur.setup0;
        SEL_TALLY_1: next_cur.setup1 = cur.setup1;
      endcase
    end
    if (regRead && privileged) begin
      unique case (regSel)
        SEL_SETUP_0: next_cur.readData = {8'h00, cur.setup0};
        SEL_SETUP_1: next_cur.readData = {8'h00, cur.setup1};
        SEL_TALLY_0: next_cur.readData = tally0;
        SEL_TALLY_1: next_cur.readData = tally1;
      endcase
    end

    // counter read: samples the live tally at once, no ordering wait
    if (counterRead) begin
      if (privileged || controlRegisterFour[PERMIT_BIT]) begin
        next_cur.ctrData = counterIndex ? tally1 : tally0;
        next_cur.ctrFault = 1'b0;
      end else begin
        next_cur.ctrFault = 1'b1;
      end
    end else begin
      next_cur.ctrFault = 1'b0;
    end

    // pins: latch a request, raise for one bus clock, then drop
    // back-to-back requests inside one bus clock merge into one toggle, unless one lands on the tick that raises the pin
    for (int i = 0; i < 2; i++) begin
      if (toggleReq[i]) begin
        next_cur.pinPending[i] = 1'b1;
      end
      if (busTick) begin
        next_cur.pin[i] = cur.pinPending[i] & ~cur.pin[i];
        if (cur.pinPending[i] && !cur.pin[i] && !toggleReq[i]) begin
          next_cur.pinPending[i] = 1'b0;
        end
      end
    end

    // overflow interrupt pulse when enabled per lane
    next_cur.irq[0] = wrapped0 & cur.setup0[IRQ_BIT];
    next_cur.irq[1] = wrapped1 & cur.setup1[IRQ_BIT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign regReadData = cur.readData;
  assign regFault = cur.regFault;
  assign counterReadData = cur.ctrData;
  assign counterReadFault = cur.ctrFault;
  assign setupCode0 = cur.setup0[CODE_MSB:CODE_LSB];
  assign setupCode1 = cur.setup1[CODE_MSB:CODE_LSB];
  assign unitQualifier0 = cur.setup0[QUAL_MSB:QUAL_LSB];
  assign unitQualifier1 = cur.setup1[QUAL_MSB:QUAL_LSB];
  assign monitorEventPin = cur.pin;
  assign overflowIrq = cur.irq;

  // v86 mode makes no difference to the counter read gate
  logic unusedV86;
  assign unusedV86 = v86Mode;

endmodule

// ---- sim/event_counter_props.sv ----
/*
  assertions on the ports of the dual event counter unit.
  assumes a single clk_sys domain and is bound onto the top module.
*/
`timescale 1ns/1ps
module event_counter_props
  import event_counter_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] privLevel,
  input wire logic [31:0] controlRegisterFour,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [1:0] regSel,
  input wire logic [31:0] regWriteData,
  input wire logic [39:0] regReadData,
  input wire logic regFault,
  input wire logic counterRead,
  input wire logic counterReadFault,
  input wire logic [7:0] setupCode0,
  input wire logic [7:0] setupCode1,
  input wire logic [7:0] unitQualifier0,
  input wire logic [7:0] unitQualifier1,
  input wire logic [1:0] monitorEventPin,
  input wire logic [1:0] overflowIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // named steps of a privileged access
  sequence sup_wr_s(sel);
    regWrite && privLevel == 2'h0 && regSel == sel;
  endsequence
  sequence sup_rd_s(sel);
    regRead && privLevel == 2'h0 && regSel == sel;
  endsequence
  // ==========================================================
  // access gating
  priv_fault_a: assert property (
    (regRead || regWrite) && privLevel != 2'h0 |=> regFault)
    else $error("model access at low privilege not refused");
  priv_ok_a: assert property (
    (regRead || regWrite) && privLevel == 2'h0 |=> !regFault)
    else $error("model access at level zero refused");
  user_block_a: assert property (
    counterRead && privLevel != 2'h0 && !controlRegisterFour[PERMIT_BIT]
    |=> counterReadFault) else $error("counter read not refused");
  read_permit_a: assert property (
    counterRead && (privLevel == 2'h0 || controlRegisterFour[PERMIT_BIT])
    |=> !counterReadFault) else $error("permitted counter read refused");
  // ==========================================================
  // setup fields and tally loads
  setup0_fields_a: assert property (
    sup_wr_s(SEL_SETUP_0) |=> setupCode0 == $past(regWriteData[7:0]) &&
    unitQualifier0 == $past(regWriteData[15:8]))
    else $error("setup 0 fields not taken");
  setup1_fields_a: assert property (
    sup_wr_s(SEL_SETUP_1) |=> setupCode1 == $past(regWriteData[7:0]) &&
    unitQualifier1 == $past(regWriteData[15:8]))
    else $error("setup 1 fields not taken");
  tally_sign_a: assert property (
    sup_wr_s(SEL_TALLY_0) ##2 sup_rd_s(SEL_TALLY_0)
    |=> regReadData[39:32] == {8{$past(regWriteData[31], 3)}})
    else $error("tally load not sign extended");
  // ==========================================================
  // pin and interrupt pulse shapes
  pin_width_a: assert property (
    $rose(monitorEventPin[0]) |=> monitorEventPin[0] ##1 !monitorEventPin[0])
    else $error("monitor pin pulse not one bus clock");
  irq_pulse_a: assert property (
    overflowIrq[0] |=> !overflowIrq[0]) else $error("overflow request held");
endmodule

bind dual_event_counter_unit event_counter_props u_props (
  .clk_sys(clk_sys), .rst(rst), .privLevel(privLevel),
  .controlRegisterFour(controlRegisterFour), .regRead(regRead),
  .regWrite(regWrite), .regSel(regSel), .regWriteData(regWriteData),
  .regReadData(regReadData), .regFault(regFault), .counterRead(counterRead),
  .counterReadFault(counterReadFault), .setupCode0(setupCode0),
  .setupCode1(setupCode1), .unitQualifier0(unitQualifier0),
  .unitQualifier1(unitQualifier1), .monitorEventPin(monitorEventPin),
  .overflowIrq(overflowIrq));

// ---- sim/core_event_source.sv ----
/*
  core side event source: bursts of per-cycle event counts for both lanes.
  assumes the bench pulses go for one clock while level and len hold.
*/
`timescale 1ns/1ps
module core_event_source (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] level,
  input wire logic [7:0] len,
  output logic [7:0] eventCount0,
  output logic [7:0] eventCount1
);
  logic [7:0] left; // burst cycles still to come
  // ==========================================================
  // len cycles at level, zero between bursts so idle never counts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left <= 8'h00;
      eventCount0 <= 8'h00;
    end else if (go) begin
      left <= len - 8'h01;
      eventCount0 <= level; // level one acts as a duration condition
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end else begin
      eventCount0 <= 8'h00;
    end
  end
  assign eventCount1 = eventCount0; // both lanes watch the same source
endmodule

// ---- sim/tb.sv ----
/*
  self-checking bench for the dual event counter unit.
  assumes the core event source model and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb
  import event_counter_pkg::*;
;
  logic clk_sys = 0, rst = 1, v86Mode = 0, go = 0, counterIndex = 0;
  logic regRead = 0, regWrite = 0, counterRead = 0;
  logic [1:0] privLevel = 0, regSel = 0, p, monitorEventPin, overflowIrq;
  logic [31:0] controlRegisterFour = 0, regWriteData = 0, s, st;
  logic [7:0] level = 0, len = 1, lvl, n, eventCount0, eventCount1;
  logic [7:0] setupCode0, setupCode1, unitQualifier0, unitQualifier1;
  logic [39:0] regReadData, counterReadData, d, g;
  logic regFault, counterReadFault;
  int n_mismatch = 0, checks = 0, irqs = 0, pinHi = 0, faults = 0;
  dual_event_counter_unit u_dual_event_counter_unit (.clk_sys(clk_sys),
    .rst(rst), .privLevel(privLevel), .v86Mode(v86Mode),
    .controlRegisterFour(controlRegisterFour), .eventCount0(eventCount0),
    .eventCount1(eventCount1), .regRead(regRead), .regWrite(regWrite),
    .regSel(regSel), .regWriteData(regWriteData), .regReadData(regReadData),
    .regFault(regFault), .counterRead(counterRead),
    .counterIndex(counterIndex), .counterReadData(counterReadData),
    .counterReadFault(counterReadFault), .setupCode0(setupCode0),
    .setupCode1(setupCode1), .unitQualifier0(unitQualifier0),
    .unitQualifier1(unitQualifier1), .monitorEventPin(monitorEventPin),
    .overflowIrq(overflowIrq));
  core_event_source u_core_event_source (.clk_sys(clk_sys), .rst(rst),
    .go(go), .level(level), .len(len), .eventCount0(eventCount0),
    .eventCount1(eventCount1));
  // ==========================================================
  // clock and sticky event counters (irq pulses last one cycle, pin pulses BUS_DIV cycles)
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // sampled mid-cycle so outputs are settled, away from the launch edge
  always @(negedge clk_sys) begin
    irqs += overflowIrq[0];
    pinHi += monitorEventPin[0];
    faults += regFault + counterReadFault;
  end
  // ==========================================================
  // expected gain of one burst, worked out from the setup fields
  function automatic logic [39:0] gain(input logic [31:0] su,
      input logic [1:0] pl, input int lv, input int nb);
    int q;
    if (!su[GLOBAL_BIT] || !(pl == 0 ? su[SUPER_BIT] : su[USER_BIT])) begin
      return 40'h00_0000_0000;
    end
    q = (su[31:24] == 0) ? lv : int'(lv >= su[31:24]);
    return su[EDGE_BIT] ? 40'(q != 0) : 40'(q * nb);
  endfunction
  // ==========================================================
  // bus steps: driven 1 ns after the edge, one take edge each
  task automatic wr(input logic [1:0] sl, input logic [31:0] v);
    @(posedge clk_sys) #1;
    regWrite = 1;
    regSel = sl;
    regWriteData = v;
    @(posedge clk_sys) #1;
    regWrite = 0;
  endtask
  // pmc picks the counter read path, otherwise a model read
  task automatic rd(input bit pmc, input logic [1:0] sl, output logic [39:0] v);
    @(posedge clk_sys) #1;
    regSel = sl;
    counterIndex = sl[0];
    regRead = !pmc;
    counterRead = pmc;
    @(posedge clk_sys) #1;
    regRead = 0;
    counterRead = 0;
    @(posedge clk_sys) #1;
    v = pmc ? counterReadData : regReadData;
  endtask
  task automatic burst(input logic [7:0] l, input logic [7:0] nb);
    @(posedge clk_sys) #1;
    go = 1;
    level = l;
    len = nb;
    @(posedge clk_sys) #1;
    go = 0;
    repeat (nb + 6) @(posedge clk_sys);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: whole run is well under 5000 cycles
  initial begin
    #(25 * 5000);
    n_mismatch++;
    complete_run;
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(33132));
    repeat (16) @(posedge clk_sys);
    #1 rst = 0;
    rd(0, SEL_SETUP_0, d); `CHK("setup0 reset", {8'h00, SETUP_RESET}, d)
    rd(0, SEL_TALLY_1, d); `CHK("tally1 reset", TALLY_RESET, d)
    wr(SEL_TALLY_0, 32'h8000_0000);
    rd(0, SEL_TALLY_0, d); `CHK("tally neg", 40'hFF_8000_0000, d)
    // random setups: privilege, edge, threshold and start value
    for (int i = 0; i < 12; i++) begin
      p = 2'($urandom);
      lvl = 8'(1 + $urandom % 3);
      n = 8'(1 + $urandom % 8);
      st = $urandom;
      s = {8'($urandom % 4), 5'h08, 3'($urandom), 16'($urandom)};
      wr(SEL_TALLY_0, st);
      wr(SEL_SETUP_0, s); // enable write before the burst
      rd(0, SEL_SETUP_0, d); `CHK("setup0", {8'h00, s}, d)
      privLevel = p;
      v86Mode = 1'($urandom);
      burst(lvl, n);
      privLevel = 0;
      wr(SEL_SETUP_0, 32'h0000_0000);
      g = {{8{st[31]}}, st} + gain(s, p, lvl, n);
      rd(0, SEL_TALLY_0, d); `CHK("tally0", g, d)
    end
    // global enable in setup 0 only; clearing setup 1 stops lane 1 only
    wr(SEL_TALLY_0, 32'h0000_0000);
    wr(SEL_TALLY_1, 32'h0000_0000);
    wr(SEL_SETUP_1, 32'h0003_0000);
    wr(SEL_SETUP_0, 32'h0043_0000);
    burst(2, 3);
    wr(SEL_SETUP_1, 32'h0000_0000);
    burst(2, 3);
    wr(SEL_SETUP_0, 32'h0003_0000);
    burst(2, 3);
    g = gain(32'h0043_0000, 0, 2, 3);
    rd(0, SEL_TALLY_0, d); `CHK("tally0 lanes", 2 * g, d)
    rd(0, SEL_TALLY_1, d); `CHK("tally1 lanes", g, d)
    // refused accesses, then a permitted user counter read
    faults = 0;
    privLevel = 2'h3;
    wr(SEL_TALLY_0, 32'h0000_0005);
    rd(1, SEL_TALLY_0, d);
    `CHK("faults", 2, faults)
    controlRegisterFour = 32'h0000_0100;
    rd(1, SEL_TALLY_0, d); `CHK("user read", 2 * g, d)
    privLevel = 0;
    // overflow: wrap raises the request and one pin pulse
    wr(SEL_TALLY_0, 32'hFFFF_FFFF);
    wr(SEL_SETUP_0, 32'h0053_0000);
    irqs = 0;
    pinHi = 0;
    burst(1, 1);
    `CHK("irqs", 1, irqs)
    `CHK("pin ovf", BUS_DIV, pinHi)
    wr(SEL_SETUP_0, 32'h005B_0000);
    irqs = 0;
    pinHi = 0;
    burst(2, 1);
    `CHK("pin count", BUS_DIV, pinHi)
    `CHK("no irq", 0, irqs)
    complete_run;
  end
endmodule
